// >>> rtl/facc_top.sv
// frame acquisition sequencer: frame limit, burst trigger, free-run
`timescale 1ns/1ps
`default_nettype none
`include "facc_params.svh"
module facc_top
    import facc_pkg::*;
#(
    parameter int CNT_W = `FACC_CNT_W
) (
    // clock, reset, enable
    input wire logic clock,
    input wire logic rst,
    input wire logic clk_en,
    // host configuration and commands
    input wire facc_pkg::facc_cfg_t cfg,
    input wire logic acq_start,
    input wire logic acq_stop,
    // external frame start trigger pin
    input wire logic frame_trigger_pin,
    // image streaming path
    input wire logic frame_done,
    output logic exposure_start,
    output logic transfer_start,
    // status
    output facc_pkg::facc_status_t status,
    output logic acq_done,
    output logic trigger_rejected
);
    import facc_pkg::*;

    facc_state_t state;
    facc_state_t next_state;
    facc_cfg_t cfg_q;
    logic [2:0] trig_sync;
    logic trig_level;
    logic trig_rise;
    logic stop_pending;
    logic [CNT_W-1:0] xfer_count;
    logic [CNT_W-1:0] burst_count;
    logic [CNT_W-1:0] burst_eff;
    logic burst_mode;
    logic limit_ok;
    logic burst_pending;
    logic clear_all;
    logic clear_burst;
    logic issue_frame;
    logic frame_end;

    // trigger pin: three flops, a change counts when the last two agree
    always_ff @(posedge clock) begin
        if (rst) begin
            trig_sync <= `FACC_SYNC_RST;
        end else if (clk_en) begin
            trig_sync <= {trig_sync[1:0], frame_trigger_pin};
        end
    end

    // filtered trigger level
    always_ff @(posedge clock) begin
        if (rst) begin
            trig_level <= 1'b0;
        end else if (clk_en && (trig_sync[1] == trig_sync[2])) begin
            trig_level <= trig_sync[2];
        end
    end

    // rising edge of the filtered trigger
    assign trig_rise = (trig_sync[1] == trig_sync[2]) && trig_sync[2] && !trig_level;

    // configuration is held steady for the whole acquisition
    always_ff @(posedge clock) begin
        if (rst) begin
            cfg_q <= '0;
        end else if (clk_en && state == FACC_IDLE && acq_start) begin
            cfg_q <= cfg;
        end
    end

    // derived mode terms
    assign burst_mode = cfg_q.trigger_enable
                        && (cfg_q.trigger_sequence_select == `FACC_SEQ_BURST);
    // a zero burst setting still exposes one frame
    assign burst_eff = (cfg_q.burst_frame_count == `FACC_CNT_ZERO) ? `FACC_CNT_ONE
                       : cfg_q.burst_frame_count;
    // room for another transfer under the frame limit
    assign limit_ok = (cfg_q.acquisition_mode_select != `FACC_MODE_BOUNDED)
                      || (xfer_count < cfg_q.acquisition_frame_limit);
    // burst still owes exposures from the last trigger
    assign burst_pending = burst_mode && (burst_count != `FACC_CNT_ZERO)
                           && (burst_count < burst_eff);

    // counter controls
    assign clear_all = (state == FACC_IDLE) && acq_start;
    assign clear_burst = clear_all || ((state == FACC_WAIT) && trig_rise && !stop_pending);
    assign frame_end = (state == FACC_FRAME) && frame_done;

    // next state and frame issue
    always_comb begin
        next_state = state;
        issue_frame = 1'b0;
        case (state)
            FACC_IDLE: begin
                if (acq_start) begin
                    next_state = FACC_LAUNCH;
                end
            end
            FACC_LAUNCH: begin
                if (stop_pending || !limit_ok) begin
                    next_state = FACC_IDLE;
                end else if (!cfg_q.trigger_enable || burst_pending) begin
                    issue_frame = 1'b1;
                    next_state = FACC_FRAME;
                end else begin
                    next_state = FACC_WAIT;
                end
            end
            FACC_WAIT: begin
                if (stop_pending) begin
                    next_state = FACC_IDLE;
                end else if (trig_rise) begin
                    issue_frame = 1'b1;
                    next_state = FACC_FRAME;
                end
            end
            FACC_FRAME: begin
                if (frame_done) begin
                    next_state = FACC_LAUNCH;
                end
            end
            default: begin
                next_state = FACC_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge clock) begin
        if (rst) begin
            state <= FACC_IDLE;
        end else if (clk_en) begin
            state <= next_state;
        end
    end

    // stop request: finishes the current frame first
    always_ff @(posedge clock) begin
        if (rst) begin
            stop_pending <= 1'b0;
        end else if (clk_en) begin
            if (state == FACC_IDLE) begin
                stop_pending <= 1'b0;
            end else if (acq_stop) begin
                stop_pending <= 1'b1;
            end
        end
    end

    // transferred frames
    facc_counter #(.W(CNT_W)) u_xfer_cnt (
        .clock(clock),
        .rst(rst),
        .clk_en(clk_en),
        .clear(clear_all),
        .inc(frame_end),
        .value(xfer_count)
    );

    // exposures in the current burst
    facc_counter #(.W(CNT_W)) u_burst_cnt (
        .clock(clock),
        .rst(rst),
        .clk_en(clk_en),
        .clear(clear_burst),
        .inc(issue_frame),
        .value(burst_count)
    );

    // frame start pulses toward exposure and stream
    always_ff @(posedge clock) begin
        if (rst) begin
            exposure_start <= 1'b0;
            transfer_start <= 1'b0;
        end else if (clk_en) begin
            exposure_start <= issue_frame;
            transfer_start <= issue_frame;
        end
    end

    // end of acquisition and trigger rejection pulses
    always_ff @(posedge clock) begin
        if (rst) begin
            acq_done <= 1'b0;
            trigger_rejected <= 1'b0;
        end else if (clk_en) begin
            acq_done <= (state != FACC_IDLE) && (next_state == FACC_IDLE);
            trigger_rejected <= trig_rise && (state != FACC_WAIT);
        end
    end

    // host status
    always_ff @(posedge clock) begin
        if (rst) begin
            status <= '0;
        end else if (clk_en) begin
            status.acq_active <= (next_state != FACC_IDLE);
            status.trigger_wait <= (next_state == FACC_WAIT);
            // shows the cleared count at the same edge as the counter clears
            if (clear_all) begin
                status.transferred_count <= `FACC_CNT_ZERO;
            end else begin
                status.transferred_count <= frame_end ? xfer_count + CNT_W'(1) : xfer_count;
            end
        end
    end

    // checks on the sequencer
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst || !clk_en);

    sequence s_frame_closed;
        (state == FACC_FRAME) && frame_done;
    endsequence

    sequence s_burst_owed;
        (state == FACC_LAUNCH) && burst_pending && limit_ok && !stop_pending;
    endsequence

    a_bounded_cap: assert property (
        (state == FACC_FRAME) && (cfg_q.acquisition_mode_select == `FACC_MODE_BOUNDED)
        |-> xfer_count < cfg_q.acquisition_frame_limit)
        else $error("transfer beyond frame limit");

    a_burst_cap: assert property (
        (state == FACC_FRAME) && burst_mode |-> burst_count <= burst_eff)
        else $error("burst exposed too many frames");

    a_free_run: assert property (
        (state == FACC_LAUNCH) && !cfg_q.trigger_enable && limit_ok && !stop_pending
        |=> exposure_start && transfer_start && state == FACC_FRAME)
        else $error("free run frame not issued");

    a_trig_frame: assert property (
        (state == FACC_WAIT) && !stop_pending && trig_rise
        |=> exposure_start && transfer_start)
        else $error("accepted trigger gave no frame");

    a_wait_idle: assert property (
        (state == FACC_WAIT) && !trig_rise |=> !exposure_start)
        else $error("frame exposed without trigger");

    a_burst_chain: assert property (
        s_frame_closed ##1 s_burst_owed |=> exposure_start ##1 (state == FACC_FRAME))
        else $error("burst did not continue");

    a_limit_end: assert property (
        (state == FACC_LAUNCH) && !limit_ok |=> acq_done && (state == FACC_IDLE))
        else $error("limit reached but acquisition continues");

    a_start_clear: assert property (
        (state == FACC_IDLE) && acq_start
        |=> (xfer_count == `FACC_CNT_ZERO) && (burst_count == `FACC_CNT_ZERO))
        else $error("counters not cleared at start");

endmodule // facc_top
`default_nettype wire

// >>> common/facc_params.svh
// constants for the frame acquisition count controller
`ifndef FACC_PARAMS_SVH
`define FACC_PARAMS_SVH

// width of frame counts and limits
`define FACC_CNT_W 16
// width of the trigger sequence selector
`define FACC_SEQ_W 4
// trigger sequences: one frame per trigger
`define FACC_SEQ_SINGLE_A 4'h0
`define FACC_SEQ_SINGLE_B 4'h1
// trigger sequence: burst of frames per trigger
`define FACC_SEQ_BURST 4'h6
// acquisition mode select codes
`define FACC_MODE_CONTINUOUS 1'b0
`define FACC_MODE_BOUNDED 1'b1
// counter reset value and smallest effective burst
`define FACC_CNT_ZERO 16'h0000
`define FACC_CNT_ONE 16'h0001
// synchroniser reset level
`define FACC_SYNC_RST 3'h0

`endif

// >>> common/facc_pkg.sv
// types for the frame acquisition count controller
`include "facc_params.svh"
package facc_pkg;

    // acquisition and trigger configuration from the host
    typedef struct packed {
        logic acquisition_mode_select;
        logic [`FACC_CNT_W-1:0] acquisition_frame_limit;
        logic trigger_enable;
        logic [`FACC_SEQ_W-1:0] trigger_sequence_select;
        logic [`FACC_CNT_W-1:0] burst_frame_count;
    } facc_cfg_t;

    // status seen by the host
    typedef struct packed {
        logic acq_active;
        logic trigger_wait;
        logic [`FACC_CNT_W-1:0] transferred_count;
    } facc_status_t;

    // sequencer states, one-hot
    typedef enum logic [3:0] {
        FACC_IDLE   = 4'b0001,
        FACC_LAUNCH = 4'b0010,
        FACC_WAIT   = 4'b0100,
        FACC_FRAME  = 4'b1000
    } facc_state_t;

endpackage

// >>> rtl/facc_counter.sv
// frame counter with clear and increment
`timescale 1ns/1ps
`default_nettype none
`include "facc_params.svh"
module facc_counter #(
    parameter int W = `FACC_CNT_W
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    input wire logic clk_en,
    // control
    input wire logic clear,
    input wire logic inc,
    // count
    output logic [W-1:0] value
);

    // clear wins, but an increment in the same cycle counts as the first
    always_ff @(posedge clock) begin
        if (rst) begin
            value <= '0;
        end else if (clk_en) begin
            if (clear) begin
                value <= inc ? W'(1) : '0;
            end else if (inc) begin
                value <= value + W'(1);
            end
        end
    end

endmodule // facc_counter
`default_nettype wire

// >>> sim/facc_partner.sv
// stream path and trigger source model facing the sequencer
`timescale 1ns/1ps
`default_nettype none
module facc_partner (
    // clock
    input wire logic clock,
    // sequencer side
    input wire logic transfer_start,
    output logic frame_done,
    output logic frame_trigger_pin,
    // bench control
    input wire logic [3:0] lat,
    input wire logic trig_req,
    output logic trig_busy
);
    logic [3:0] dcnt = 4'h0;
    logic [3:0] tcnt = 4'h0;
    initial frame_done = 1'b0;
    // one frame_done per transfer, lat cycles later
    always @(posedge clock) begin
        dcnt <= (transfer_start === 1'b1) ? lat : (dcnt != 4'h0 ? dcnt - 4'h1 : dcnt);
        frame_done <= (dcnt == 4'h1) && (transfer_start !== 1'b1);
    end
    // trigger high 4 cycles then low 4 before the next one
    always @(posedge clock) begin
        tcnt <= trig_req ? 4'h8 : (tcnt != 4'h0 ? tcnt - 4'h1 : tcnt);
    end
    assign frame_trigger_pin = tcnt > 4'h4;
    assign trig_busy = trig_req || tcnt != 4'h0;
endmodule // facc_partner
`default_nettype wire

// >>> sim/facc_top_tb_top.sv
// self-checking bench for the frame acquisition sequencer
`timescale 1ns/1ps
`default_nettype none
module facc_top_tb_top;
    import facc_pkg::*;
    typedef struct packed {
        facc_cfg_t cfg;
        logic [3:0] ntrig;
        logic stop;
        logic poke;
        logic [3:0] lat;
        logic [15:0] exp;
    } facc_row_t;
    logic clock = 1'b0;
    logic rst, clk_en, acq_start, acq_stop, pin, frame_done, trig_req, trig_busy;
    logic exposure_start, transfer_start, acq_done, trigger_rejected;
    logic [3:0] lat;
    facc_cfg_t cfg;
    facc_status_t status;
    facc_row_t rows [10];
    int failures = 0;
    int checked = 0;
    int n_xfer = 0;
    int n_exp = 0;
    int n_rej = 0;
    // clock
    always #20 clock = ~clock;
    facc_top #(.CNT_W(16)) dut (.clock(clock), .rst(rst), .clk_en(clk_en), .cfg(cfg),
        .acq_start(acq_start), .acq_stop(acq_stop), .frame_trigger_pin(pin),
        .frame_done(frame_done), .exposure_start(exposure_start),
        .transfer_start(transfer_start), .status(status), .acq_done(acq_done),
        .trigger_rejected(trigger_rejected));
    facc_partner u_partner (.clock(clock), .transfer_start(transfer_start),
        .frame_done(frame_done), .frame_trigger_pin(pin), .lat(lat),
        .trig_req(trig_req), .trig_busy(trig_busy));
    // pulse counters
    always @(posedge clock) begin
        n_xfer += int'(transfer_start === 1'b1);
        n_exp += int'(exposure_start === 1'b1);
        n_rej += int'(trigger_rejected === 1'b1);
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // one acquisition: start, feed triggers, optional stop, count frames
    task automatic run_row(input facc_row_t r);
        int left, cyc, bx, be;
        logic done;
        left = r.ntrig;
        bx = n_xfer;
        be = n_exp;
        done = 1'b0;
        @(posedge clock);
        lat <= r.lat;
        cfg <= r.cfg;
        acq_start <= 1'b1;
        @(posedge clock);
        acq_start <= 1'b0;
        @(posedge clock);
        check(32'({status.acq_active, status.transferred_count}), 32'h0001_0000);
        for (cyc = 0; cyc < 600 && !done; cyc++) begin
            @(posedge clock);
            done = acq_done;
            trig_req <= status.trigger_wait && left > 0 && !trig_busy;
            if (status.trigger_wait && left > 0 && !trig_busy) left--;
            acq_stop <= r.stop && status.trigger_wait && left == 0 && !trig_busy
                && !acq_stop && (n_xfer - bx) >= int'(r.exp);
            acq_start <= r.poke && cyc == 6;
        end
        @(posedge clock);
        trig_req <= 1'b0;
        acq_stop <= 1'b0;
        acq_start <= 1'b0;
        check(32'({done, status.acq_active, status.transferred_count}),
            {14'h0000, 1'b1, 1'b0, r.exp});
        check(32'(n_xfer - bx), 32'(r.exp));
        check(32'(n_exp - be), 32'(r.exp));
    endtask
    // watchdog
    initial begin
        repeat (20000) @(posedge clock);
        failures++;
        report_and_stop;
    end
    // main sequence
    initial begin
        rst = 1'b1;
        clk_en = 1'b1;
        cfg = '0;
        acq_start = 1'b0;
        acq_stop = 1'b0;
        trig_req = 1'b0;
        lat = 4'h1;
        rows[0] = '{'{1'b1, 16'h0003, 1'b0, 4'h0, 16'h0000}, 4'h0, 1'b0, 1'b1, 4'h2, 16'h0003};
        rows[1] = '{'{1'b1, 16'h0002, 1'b1, 4'h0, 16'h0000}, 4'h2, 1'b0, 1'b0, 4'h5, 16'h0002};
        rows[2] = '{'{1'b1, 16'h0002, 1'b1, 4'h1, 16'h0000}, 4'h2, 1'b0, 1'b0, 4'h1, 16'h0002};
        rows[3] = '{'{1'b1, 16'h0002, 1'b1, 4'h3, 16'h0000}, 4'h2, 1'b0, 1'b0, 4'h3, 16'h0002};
        rows[4] = '{'{1'b0, 16'h0001, 1'b1, 4'h6, 16'h0003}, 4'h1, 1'b1, 1'b0, 4'h2, 16'h0003};
        rows[5] = '{'{1'b1, 16'h0002, 1'b1, 4'h6, 16'h0003}, 4'h1, 1'b0, 1'b0, 4'h2, 16'h0002};
        rows[6] = '{'{1'b1, 16'h0004, 1'b1, 4'h6, 16'h0003}, 4'h2, 1'b0, 1'b0, 4'h1, 16'h0004};
        rows[7] = '{'{1'b1, 16'h0000, 1'b0, 4'h0, 16'h0000}, 4'h0, 1'b0, 1'b0, 4'h1, 16'h0000};
        rows[8] = '{'{1'b0, 16'h0000, 1'b1, 4'h6, 16'h0000}, 4'h1, 1'b1, 1'b0, 4'h4, 16'h0001};
        rows[9] = '{'{1'b0, 16'h0000, 1'b1, 4'h0, 16'h0000}, 4'h2, 1'b1, 1'b0, 4'h1, 16'h0002};
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        repeat (2) @(posedge clock);
        check(32'({acq_done, trigger_rejected, exposure_start, transfer_start, status}),
            '0);
        // trigger while idle is refused with no frame
        trig_req <= 1'b1;
        @(posedge clock);
        trig_req <= 1'b0;
        repeat (12) @(posedge clock);
        check(32'({n_rej[7:0], n_xfer[7:0]}), 32'h0000_0100);
        for (int i = 0; i < 10; i++) run_row(rows[i]);
        // clock enable low freezes a waiting acquisition, a stop meanwhile is lost
        @(posedge clock);
        cfg <= rows[1].cfg;
        acq_start <= 1'b1;
        @(posedge clock);
        acq_start <= 1'b0;
        repeat (3) @(posedge clock);
        clk_en <= 1'b0;
        acq_stop <= 1'b1;
        @(posedge clock);
        acq_stop <= 1'b0;
        repeat (4) @(posedge clock);
        clk_en <= 1'b1;
        repeat (3) @(posedge clock);
        check(32'({status.acq_active, status.trigger_wait, acq_done}), 32'h0000_0006);
        // reset in mid-run returns to idle with all outputs low
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        repeat (2) @(posedge clock);
        check(32'({acq_done, trigger_rejected, exposure_start, transfer_start, status}),
            32'h0000_0000);
        report_and_stop;
    end
endmodule // facc_top_tb_top
`default_nettype wire
